// [rtl/rsl_delay_cnt.sv]
module rsl_delay_cnt #(
   parameter int W = 12,
   parameter int COUNT = 400
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic run_i,
   output logic done_o
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic done;
   } rsl_cnt_s;

   rsl_cnt_s r_reg;
   rsl_cnt_s r_next;

   // Restarts from zero whenever run drops, so a glitch on the
   // enabling condition always costs the full delay again
   always_comb begin
      r_next = r_reg;
      if (!run_i) begin
         r_next.cnt = '0;
         r_next.done = 1'b0;
      end else if (!r_reg.done) begin
         if (r_reg.cnt == W'(COUNT - 1)) begin
            r_next.done = 1'b1;
         end else begin
            r_next.cnt = r_reg.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign done_o = r_reg.done;

endmodule

// [rtl/rsl_pkg.sv]
package rsl_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_MHZ = 40;
   // Supply settle time after the detector says power is up
   localparam int PWR_STABLE_NS = 10000;
   localparam int PWR_STABLE_CYC = (PWR_STABLE_NS * CLK_FREQ_MHZ + 999) / 1000;
   // Oscillator warm-up time before the core clock is trusted
   localparam int WARMUP_NS = 50000;
   localparam int WARMUP_CYC = (WARMUP_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int CNT_W = 12;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] IDX_PROGRAM_FLAGS = 12'h086;
   localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h087;
   localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE = 12'h088;
   localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR = 12'h089;

   // ----------------------------------------------------------------
   // Field positions of program_flags
   // ----------------------------------------------------------------
   localparam int FLD_CAUSE_HI = 7;
   localparam int FLD_CAUSE_LO = 6;
   localparam int FLD_HIGH_FLAG = 5;
   localparam int FLD_MID_FLAG = 4;
   localparam int FLD_ALU_HI = 2;

   // ----------------------------------------------------------------
   // Reset-cause codes and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] CAUSE_WATCHDOG = 2'h0;
   localparam logic [1:0] CAUSE_RESERVED = 2'h1;
   localparam logic [1:0] CAUSE_POWER = 2'h2;
   localparam logic [1:0] CAUSE_PIN = 2'h3;
   localparam logic [1:0] CAUSE_RST = CAUSE_POWER;
   localparam logic [2:0] ALU_FLAGS_RST = 3'h0;
   localparam logic [31:0] PC_ORIGIN = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Interrupt status bits
   // ----------------------------------------------------------------
   localparam int IRQ_W = 3;
   localparam int IRQ_STARTED = 0;
   localparam int IRQ_MID_LOW = 1;
   localparam int IRQ_HIGH_LOW = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // ----------------------------------------------------------------
   // Detector configuration option codes
   // ----------------------------------------------------------------
   localparam logic [1:0] OPT_LOW = 2'h0;
   localparam logic [1:0] OPT_MID = 2'h1;
   localparam logic [1:0] OPT_HIGH = 2'h2;
   localparam logic [1:0] OPT_MAX = 2'h3;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_POWER_UP = 5'h01,
      ST_PIN_CHECK = 5'h02,
      ST_INIT = 5'h04,
      ST_WARMUP = 5'h08,
      ST_RUN = 5'h10
   } rsl_state_e;

endpackage

// [rtl/rsl_reset_ctrl.sv]
// Notes on behaviour
// - Any reset halts core, clears registers, PC
// - Execution restarts at program address zero
// - Cause in flags bits 7:6; 00 watchdog
// - Power-on or detector reset records 10
// - Reset pin low records 11
// - Supply settle, pin, init, warm-up, run
// - Enabled pin held low keeps reset
// - Run only after warm-up and clock valid
// - Watchdog overflow: init, warm-up, restart
// - Enabled threshold crossing triggers system reset
// - Lowest threshold resets in every option
// - Middle resets high/max; top resets max
// - Bit 5 high-level flag, high option
// - Bit 4 mid-level flag, mid option
// - Low option: both flags held off
// - Detector reset clears both indicator flags
// - Pin resets only when option enables it
//
// Implementation choice: the APB interface to the registers.
module rsl_reset_ctrl #(
   parameter int PWR_CYC = rsl_pkg::PWR_STABLE_CYC,
   parameter int WARM_CYC = rsl_pkg::WARMUP_CYC,
   parameter int PC_W = 12
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [rsl_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Supply comparators
   input wire logic supply_up_i,
   input wire logic vdd_below_2v0_i,
   input wire logic vdd_below_2v4_i,
   input wire logic vdd_below_3v6_i,
   input wire logic vdd_le_2v4_i,
   input wire logic vdd_le_3v6_i,
   // Factory configuration
   input wire logic [1:0] detector_opt_i,
   input wire logic reset_pin_en_i,
   // Watchdog, reset pin and oscillator
   input wire logic wdt_overflow_i,
   input wire logic reset_pin_i,
   input wire logic osc_ready_i,
   output logic osc_enable_o,
   // Core control
   output logic core_reset_o,
   output logic regs_init_o,
   output logic pc_load_o,
   output logic [PC_W-1:0] pc_start_o,
   output logic [1:0] reset_cause_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      rsl_pkg::rsl_state_e st;
      logic [1:0] cause;
      logic [2:0] alu;
      logic mid_flag;
      logic high_flag;
      logic [rsl_pkg::IRQ_W-1:0] irq_stat;
      logic [rsl_pkg::IRQ_W-1:0] irq_en;
      logic [31:0] prdata;
      logic pslverr;
      logic regs_init;
      logic pc_load;
   } rsl_ctrl_s;

   rsl_ctrl_s r_reg;
   rsl_ctrl_s r_next;

   logic pwr_done;
   logic warm_done;
   logic lvd_trip;
   logic pin_trip;
   logic mid_now;
   logic high_now;
   logic rd_hit;
   logic wr_en;
   logic [7:0] flags_val;
   logic [31:0] rd_word;
   logic wr_flags;
   logic wr_irq_en;
   logic wr_irq_clr;
   logic [rsl_pkg::IRQ_W-1:0] irq_set;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic reg_sel(input logic [rsl_pkg::ADDR_W-1:0] a,
                                    input logic [rsl_pkg::ADDR_W-1:0] idx);
      reg_sel = (a == rsl_pkg::ADDR_W'({idx, 2'b00}));
   endfunction

   // ----------------------------------------------------------------
   // Option decode
   // ----------------------------------------------------------------
   // Reset and flag duties of the comparators follow different options
   function automatic logic mid_resets(input logic [1:0] opt);
      mid_resets = (opt == rsl_pkg::OPT_HIGH) || (opt == rsl_pkg::OPT_MAX);
   endfunction

   function automatic logic top_resets(input logic [1:0] opt);
      top_resets = (opt == rsl_pkg::OPT_MAX);
   endfunction

   // Each indicator flag lives in exactly one option
   function automatic logic mid_flag_on(input logic [1:0] opt);
      mid_flag_on = (opt == rsl_pkg::OPT_MID);
   endfunction

   function automatic logic high_flag_on(input logic [1:0] opt);
      high_flag_on = (opt == rsl_pkg::OPT_HIGH);
   endfunction

   // ----------------------------------------------------------------
   // Delay counters
   // ----------------------------------------------------------------
   rsl_delay_cnt #(
      .W(rsl_pkg::CNT_W),
      .COUNT(PWR_CYC)
   ) u_pwr_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(r_reg.st == rsl_pkg::ST_POWER_UP && supply_up_i && !lvd_trip),
      .done_o(pwr_done)
   );

   rsl_delay_cnt #(
      .W(rsl_pkg::CNT_W),
      .COUNT(WARM_CYC)
   ) u_warm_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(r_reg.st == rsl_pkg::ST_WARMUP),
      .done_o(warm_done)
   );

   // ----------------------------------------------------------------
   // Reset sources and level indicators
   // ----------------------------------------------------------------
   always_comb begin
      lvd_trip = vdd_below_2v0_i;
      if (mid_resets(detector_opt_i)) begin
         lvd_trip = lvd_trip | vdd_below_2v4_i;
      end
      if (top_resets(detector_opt_i)) begin
         lvd_trip = lvd_trip | vdd_below_3v6_i;
      end
   end

   // With the option off the pin is a plain input and never resets
   assign pin_trip = reset_pin_en_i && !reset_pin_i;

   // Low option enables neither flag
   assign mid_now = mid_flag_on(detector_opt_i) && vdd_le_2v4_i;
   assign high_now = high_flag_on(detector_opt_i) && vdd_le_3v6_i;

   // ----------------------------------------------------------------
   // Interrupt events
   // ----------------------------------------------------------------
   // Edge of the flag, not its level, so a low supply that lingers
   // does not refill the status bit right after software clears it
   always_comb begin
      irq_set = '0;
      if (r_reg.st == rsl_pkg::ST_RUN) begin
         irq_set[rsl_pkg::IRQ_MID_LOW] = mid_now && !r_reg.mid_flag;
         irq_set[rsl_pkg::IRQ_HIGH_LOW] = high_now && !r_reg.high_flag;
      end
   end

   // ----------------------------------------------------------------
   // APB access
   // ----------------------------------------------------------------
   assign rd_hit = reg_sel(paddr_i, rsl_pkg::IDX_PROGRAM_FLAGS)
      || reg_sel(paddr_i, rsl_pkg::IDX_IRQ_STATUS)
      || reg_sel(paddr_i, rsl_pkg::IDX_IRQ_ENABLE)
      || reg_sel(paddr_i, rsl_pkg::IDX_IRQ_CLEAR);
   // Every register bit sits in byte lane 0, so a write without it is dropped
   assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0];

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   assign wr_flags = wr_en && reg_sel(paddr_i, rsl_pkg::IDX_PROGRAM_FLAGS);
   assign wr_irq_en = wr_en && reg_sel(paddr_i, rsl_pkg::IDX_IRQ_ENABLE);
   assign wr_irq_clr = wr_en && reg_sel(paddr_i, rsl_pkg::IDX_IRQ_CLEAR);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   assign flags_val = {r_reg.cause, r_reg.high_flag, r_reg.mid_flag, 1'b0, r_reg.alu};

   // Unmapped and write-only words read as zero
   always_comb begin
      rd_word = '0;
      if (reg_sel(paddr_i, rsl_pkg::IDX_PROGRAM_FLAGS)) begin
         rd_word[7:0] = flags_val;
      end
      if (reg_sel(paddr_i, rsl_pkg::IDX_IRQ_STATUS)) begin
         rd_word[rsl_pkg::IRQ_W-1:0] = r_reg.irq_stat;
      end
      if (reg_sel(paddr_i, rsl_pkg::IDX_IRQ_ENABLE)) begin
         rd_word[rsl_pkg::IRQ_W-1:0] = r_reg.irq_en;
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      r_next.regs_init = 1'b0;
      r_next.pc_load = 1'b0;

      // Read data is captured in the setup cycle so it leaves a flop
      if (psel_i && !penable_i) begin
         r_next.prdata = rd_word;
         r_next.pslverr = !rd_hit;
      end

      // Software writes
      if (wr_flags) begin
         r_next.alu = pwdata_i[rsl_pkg::FLD_ALU_HI:0];
         // A write of the reserved code is dropped
         if (pwdata_i[rsl_pkg::FLD_CAUSE_HI:rsl_pkg::FLD_CAUSE_LO] != rsl_pkg::CAUSE_RESERVED) begin
            r_next.cause = pwdata_i[rsl_pkg::FLD_CAUSE_HI:rsl_pkg::FLD_CAUSE_LO];
         end
      end
      if (wr_irq_en) begin
         r_next.irq_en = pwdata_i[rsl_pkg::IRQ_W-1:0];
      end
      if (wr_irq_clr) begin
         r_next.irq_stat = r_reg.irq_stat & ~pwdata_i[rsl_pkg::IRQ_W-1:0];
      end

      // Level indicators only live while the program runs
      if (r_reg.st == rsl_pkg::ST_RUN) begin
         r_next.mid_flag = mid_now;
         r_next.high_flag = high_now;
      end else begin
         r_next.mid_flag = 1'b0;
         r_next.high_flag = 1'b0;
      end

      // Events set after the clear so a same-cycle set wins
      r_next.irq_stat = r_next.irq_stat | irq_set;

      // Reset sequencer; sources in priority order
      if (lvd_trip) begin
         if (r_reg.st != rsl_pkg::ST_POWER_UP) begin
            r_next.cause = rsl_pkg::CAUSE_POWER;
         end
         r_next.st = rsl_pkg::ST_POWER_UP;
      end else if (pin_trip && r_reg.st != rsl_pkg::ST_POWER_UP
                   && r_reg.st != rsl_pkg::ST_PIN_CHECK) begin
         r_next.cause = rsl_pkg::CAUSE_PIN;
         r_next.st = rsl_pkg::ST_PIN_CHECK;
      end else if (wdt_overflow_i && r_reg.st == rsl_pkg::ST_RUN) begin
         r_next.cause = rsl_pkg::CAUSE_WATCHDOG;
         r_next.st = rsl_pkg::ST_INIT;
      end else begin
         unique case (r_reg.st)
            rsl_pkg::ST_POWER_UP: begin
               if (pwr_done) begin
                  r_next.st = rsl_pkg::ST_PIN_CHECK;
               end
            end
            rsl_pkg::ST_PIN_CHECK: begin
               if (!pin_trip) begin
                  r_next.st = rsl_pkg::ST_INIT;
               end
            end
            rsl_pkg::ST_INIT: begin
               // Cause survives init so software can branch on it
               r_next.regs_init = 1'b1;
               r_next.alu = rsl_pkg::ALU_FLAGS_RST;
               r_next.irq_stat = rsl_pkg::IRQ_RST;
               r_next.irq_en = rsl_pkg::IRQ_RST;
               r_next.st = rsl_pkg::ST_WARMUP;
            end
            rsl_pkg::ST_WARMUP: begin
               if (warm_done && osc_ready_i) begin
                  r_next.pc_load = 1'b1;
                  r_next.irq_stat[rsl_pkg::IRQ_STARTED] = 1'b1;
                  r_next.st = rsl_pkg::ST_RUN;
               end
            end
            rsl_pkg::ST_RUN: begin
               r_next.st = rsl_pkg::ST_RUN;
            end
            default: begin
               r_next.st = rsl_pkg::ST_POWER_UP;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_reg.st <= rsl_pkg::ST_POWER_UP;
         r_reg.cause <= rsl_pkg::CAUSE_RST;
         r_reg.alu <= rsl_pkg::ALU_FLAGS_RST;
         r_reg.mid_flag <= 1'b0;
         r_reg.high_flag <= 1'b0;
         r_reg.irq_stat <= rsl_pkg::IRQ_RST;
         r_reg.irq_en <= rsl_pkg::IRQ_RST;
         r_reg.prdata <= '0;
         r_reg.pslverr <= 1'b0;
         r_reg.regs_init <= 1'b0;
         r_reg.pc_load <= 1'b0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata_o = r_reg.prdata;
   // Always ready: every register answers in the access cycle
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && r_reg.pslverr;
   assign core_reset_o = (r_reg.st != rsl_pkg::ST_RUN);
   assign regs_init_o = r_reg.regs_init;
   assign pc_load_o = r_reg.pc_load;
   assign pc_start_o = rsl_pkg::PC_ORIGIN[PC_W-1:0];
   assign osc_enable_o = (r_reg.st == rsl_pkg::ST_WARMUP) || (r_reg.st == rsl_pkg::ST_RUN);
   assign reset_cause_o = r_reg.cause;
   // Level output; it drops as soon as software clears or masks the bit
   assign irq_o = |(r_reg.irq_stat & r_reg.irq_en);

endmodule

// [test/rsl_reset_ctrl_chk.sv]
module rsl_reset_ctrl_chk #(
   parameter int PC_W = 12
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Watched inputs
   input wire logic vdd_below_2v0_i,
   input wire logic vdd_below_2v4_i,
   input wire logic vdd_below_3v6_i,
   input wire logic [1:0] detector_opt_i,
   input wire logic reset_pin_en_i,
   input wire logic reset_pin_i,
   input wire logic wdt_overflow_i,
   input wire logic osc_ready_i,
   // Watched outputs
   input wire logic osc_enable_o,
   input wire logic core_reset_o,
   input wire logic regs_init_o,
   input wire logic pc_load_o,
   input wire logic [PC_W-1:0] pc_start_o,
   input wire logic [1:0] reset_cause_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic trip;
   logic pin_req;
   assign trip = vdd_below_2v0_i | (detector_opt_i[1] & vdd_below_2v4_i)
                 | ((detector_opt_i == 2'h3) & vdd_below_3v6_i);
   assign pin_req = reset_pin_en_i & ~reset_pin_i;
   property p_det; trip |=> core_reset_o && reset_cause_o == 2'h2; endproperty
   a_det: assert property (p_det) else $error("detector trip missed");
   property p_wdt; !core_reset_o && wdt_overflow_i && !trip && !pin_req
      |=> core_reset_o && reset_cause_o == 2'h0; endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog reset missed");
   property p_pin_take; !core_reset_o && pin_req && !trip
      |=> core_reset_o && reset_cause_o == 2'h3; endproperty
   a_pin_take: assert property (p_pin_take) else $error("pin reset missed");
   property p_pin_hold; core_reset_o && pin_req |=> core_reset_o; endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("left reset with pin low");
   property p_pin_off; !core_reset_o && !reset_pin_en_i && !trip && !wdt_overflow_i
      |=> !core_reset_o; endproperty
   a_pin_off: assert property (p_pin_off) else $error("reset without cause");
   // Run may only begin from a warmed-up oscillator
   property p_run; $fell(core_reset_o) |-> pc_load_o && pc_start_o == '0
      && $past(osc_ready_i) && $past(osc_enable_o); endproperty
   a_run: assert property (p_run) else $error("bad start of execution");
   property p_init; regs_init_o |-> core_reset_o[*8]; endproperty
   a_init: assert property (p_init) else $error("run too soon after init");
   property p_no01; reset_cause_o != 2'h1; endproperty
   a_no01: assert property (p_no01) else $error("reserved cause code");
   c_wdt: cover property (!core_reset_o && wdt_overflow_i);
   c_pin: cover property (!core_reset_o && pin_req);
   c_run: cover property ($fell(core_reset_o));
endmodule

// [test/rsl_supply_model.sv]
module rsl_supply_model #(
   parameter int UP_MV = 2000,
   parameter int OSC_DLY = 12
) (
   // Clock
   input wire logic clk_i,
   // Bench controls
   input wire logic [15:0] vdd_mv_i,
   input wire logic wdt_fire_i,
   input wire logic pin_low_i,
   input wire logic osc_enable_i,
   // Toward the controller
   output logic supply_up_o,
   output logic below_2v0_o,
   output logic below_2v4_o,
   output logic below_3v6_o,
   output logic le_2v4_o,
   output logic le_3v6_o,
   output logic wdt_overflow_o,
   output logic reset_pin_o,
   output logic osc_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   assign supply_up_o = vdd_mv_i >= 16'(UP_MV);
   assign below_2v0_o = vdd_mv_i < 16'h07D0;
   assign below_2v4_o = vdd_mv_i < 16'h0960;
   assign below_3v6_o = vdd_mv_i < 16'h0E10;
   assign le_2v4_o = vdd_mv_i <= 16'h0960;
   assign le_3v6_o = vdd_mv_i <= 16'h0E10;
   // Overflow only when the bench says the program lost its single clear point
   assign wdt_overflow_o = wdt_fire_i;
   // Pin has a pull-up, so released means high
   assign reset_pin_o = ~pin_low_i;
   // Slow oscillator: longer than the warm-up count to stress the wait
   always @(posedge clk_i) begin
      n <= osc_enable_i ? (n < OSC_DLY ? n + 1 : n) : 0;
   end
   assign osc_ready_o = (n == OSC_DLY);
endmodule

// [test/test_reset_source_and_lvd_control.sv]
module test_reset_source_and_lvd_control;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------
   // Signals
   // ------------------------------
   localparam logic [11:0] A_FLAGS = rsl_pkg::IDX_PROGRAM_FLAGS << 2;
   localparam logic [11:0] A_STAT = rsl_pkg::IDX_IRQ_STATUS << 2;
   localparam logic [11:0] A_EN = rsl_pkg::IDX_IRQ_ENABLE << 2;
   localparam logic [11:0] A_CLR = rsl_pkg::IDX_IRQ_CLEAR << 2;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pin_en = 1'b0, wdt_fire = 1'b0, pin_low = 1'b0;
   logic [1:0] opt = 2'h0;
   logic [11:0] paddr = 12'h000;
   logic [15:0] vdd = 16'h1388;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic [11:0] pcs;
   logic [1:0] cause;
   logic err, pready, pslverr, sup, b20, b24, b36, l24, l36, wdt, pin, oscr, osce;
   logic core_rst, rinit, pcl, irq;
   int failures = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #12.5 clk_i = ~clk_i;
   rsl_reset_ctrl #(.PWR_CYC(4), .WARM_CYC(8)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .supply_up_i(sup), .vdd_below_2v0_i(b20),
      .vdd_below_2v4_i(b24), .vdd_below_3v6_i(b36), .vdd_le_2v4_i(l24), .vdd_le_3v6_i(l36),
      .detector_opt_i(opt), .reset_pin_en_i(pin_en), .wdt_overflow_i(wdt),
      .reset_pin_i(pin), .osc_ready_i(oscr), .osc_enable_o(osce), .core_reset_o(core_rst),
      .regs_init_o(rinit), .pc_load_o(pcl), .pc_start_o(pcs), .reset_cause_o(cause),
      .irq_o(irq));
   rsl_supply_model mdl_u (
      .clk_i(clk_i), .vdd_mv_i(vdd), .wdt_fire_i(wdt_fire), .pin_low_i(pin_low),
      .osc_enable_i(osce), .supply_up_o(sup), .below_2v0_o(b20), .below_2v4_o(b24),
      .below_3v6_o(b36), .le_2v4_o(l24), .le_3v6_o(l36), .wdt_overflow_o(wdt),
      .reset_pin_o(pin), .osc_ready_o(oscr));
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      pen <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) begin
         @(posedge clk_i);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic do_reset(input logic [1:0] o);
      rst_i <= 1'b1;
      opt <= o;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wait_run();
      @(posedge clk_i);
      while (core_rst !== 1'b0) begin
         @(posedge clk_i);
      end
      check("pc_load", pcl, 1'b1);
      check("pc_start", pcs, 12'h000);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_por();
      do_reset(2'h0);
      check("core_reset", core_rst, 1'b1);
      apb(1'b0, A_FLAGS, 32'h0);
      check("cause power-on", rd[7:6], 2'h2);
      wait_run();
      apb(1'b1, A_FLAGS, 32'h0000_0077);
      apb(1'b0, A_FLAGS, 32'h0);
      check("flags write", rd, 32'h0000_0087);
      apb(1'b0, A_STAT, 32'h0);
      check("irq status", rd, 32'h0000_0001);
      check("irq masked", irq, 1'b0);
      apb(1'b1, A_EN, 32'h0000_0001);
      check("irq raised", irq, 1'b1);
      apb(1'b1, A_CLR, 32'h0000_0001);
      check("irq cleared", irq, 1'b0);
      apb(1'b0, 12'h300, 32'h0);
      check("unmapped error", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      $display("test power-on done");
   endtask
   task automatic t_wdt();
      wdt_fire <= 1'b1;
      @(posedge clk_i);
      wdt_fire <= 1'b0;
      repeat (2) @(posedge clk_i);
      check("wdt reset", {core_rst, cause}, 3'b100);
      wait_run();
      apb(1'b0, A_FLAGS, 32'h0);
      check("flags after wdt", rd, 32'h0000_0000);
      apb(1'b0, A_EN, 32'h0);
      check("enable after wdt", rd, 32'h0000_0000);
      $display("test watchdog done");
   endtask
   task automatic t_pin();
      pin_en <= 1'b1;
      pin_low <= 1'b1;
      repeat (20) @(posedge clk_i);
      check("pin held", {core_rst, cause}, 3'b111);
      pin_low <= 1'b0;
      wait_run();
      pin_en <= 1'b0;
      pin_low <= 1'b1;
      repeat (10) @(posedge clk_i);
      check("pin ignored", core_rst, 1'b0);
      pin_low <= 1'b0;
      $display("test pin done");
   endtask
   task automatic t_lvd();
      logic [15:0] mv [4] = '{16'h0E10, 16'h0960, 16'h08FC, 16'h076C};
      logic r;
      logic [1:0] f;
      logic [2:0] s;
      for (int o = 0; o < 4; o++) begin
         do_reset(o[1:0]);
         wait_run();
         s = 3'h1;
         for (int i = 0; i < 4; i++) begin
            r = mv[i] < 16'h07D0 || (o >= 2 && mv[i] < 16'h0960) || (o == 3 && mv[i] < 16'h0E10);
            f = {o == 2 && mv[i] <= 16'h0E10, o == 1 && mv[i] <= 16'h0960};
            vdd <= mv[i];
            repeat (4) @(posedge clk_i);
            check("detector reset", core_rst, r);
            apb(1'b0, A_FLAGS, 32'h0);
            check("flags", rd[7:4], {2'h2, r ? 2'h0 : f});
            if (r) begin
               vdd <= 16'h1388;
               wait_run();
               s = 3'h1;
            end else begin
               s = s | {f, 1'b0};
               apb(1'b0, A_STAT, 32'h0);
               check("irq events", rd, {29'h0, s});
            end
         end
      end
      $display("test detector done");
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   initial begin
      t_por();
      t_wdt();
      t_pin();
      t_lvd();
      report_and_stop();
   end
endmodule
bind rsl_reset_ctrl rsl_reset_ctrl_chk #(.PC_W(PC_W)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .vdd_below_2v0_i(vdd_below_2v0_i),
   .vdd_below_2v4_i(vdd_below_2v4_i), .vdd_below_3v6_i(vdd_below_3v6_i),
   .detector_opt_i(detector_opt_i), .reset_pin_en_i(reset_pin_en_i), .reset_pin_i(reset_pin_i),
   .wdt_overflow_i(wdt_overflow_i), .osc_ready_i(osc_ready_i), .osc_enable_o(osc_enable_o),
   .core_reset_o(core_reset_o), .regs_init_o(regs_init_o), .pc_load_o(pc_load_o),
   .pc_start_o(pc_start_o), .reset_cause_o(reset_cause_o));
